//--- bstap_pkg.sv
// package for the boundary-scan test access port
// assumes a single test clock domain at the link and a functional clock domain
package bstap_pkg;

  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } bstap_state_t;

  // instruction register
  localparam int          IR_W       = 4;
  localparam logic [3:0]  IR_EXTEST  = 4'h0;
  localparam logic [3:0]  IR_SAMPLE  = 4'h1;
  localparam logic [3:0]  IR_BYPASS  = 4'hF;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;   // fixed capture pattern, low bits 01
  localparam logic [3:0]  IR_RESET   = 4'hF;   // bypass after reset

endpackage : bstap_pkg

//--- bstap_port.sv
// boundary-scan test access port: controller, instruction register,
// bypass and boundary register
// assumes the outside tester drives test_port_clock; scan pins come from the
// functional mclk_i domain and are resynchronised into the test domain
// test reset release is not synchronised: the tester holds its clock still around it
// unknown instruction codes fall back to bypass
// Summary of operation
// - low test reset clears controller at once
// - serial input captured on rising test clock
// - serial output changes on falling edge, tristateable
// - state select sampled on rising edge, drives states
// - digital pins are scan cells, not output clocks
module bstap_port #(
  parameter int NPINS = 8
) (
  // functional clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // test link
  input  wire logic             test_port_clock_i,
  input  wire logic             test_port_reset_n_i,
  input  wire logic             test_state_select_i,
  input  wire logic             test_serial_in_i,
  output logic                  test_serial_out_o,
  output logic                  test_serial_out_oe_o,
  // digital pins as scan cells (output clock pins excluded)
  input  wire logic [NPINS-1:0] core_out_i,
  input  wire logic [NPINS-1:0] pin_in_i,
  output logic [NPINS-1:0]      pin_out_o,
  output logic                  scan_mode_o
);

  bstap_pkg::bstap_state_t state;
  bstap_pkg::bstap_state_t next_state;
  logic [bstap_pkg::IR_W-1:0] ir_shift, next_ir_shift;
  logic [bstap_pkg::IR_W-1:0] ir, next_ir;
  logic                       bypass_bit, next_bypass_bit;
  logic [2*NPINS-1:0]         bsr_shift, next_bsr_shift;
  logic [NPINS-1:0]           bsr_upd, next_bsr_upd;
  logic                       tdo_q, next_tdo_q;
  logic                       oe_q, next_oe_q;
  logic [NPINS-1:0]           core_s1, core_s2, pin_s1, pin_s2;
  logic                       ext_q, next_ext_q;
  logic                       ext_s1, ext_s2;

  // instructions that route the boundary register
  function automatic logic is_bsr_instr(input logic [bstap_pkg::IR_W-1:0] code);
    return (code == bstap_pkg::IR_EXTEST) || (code == bstap_pkg::IR_SAMPLE);
  endfunction : is_bsr_instr

  // pin samples enter the test clock domain through two flops
  // core values are a snapshot; a bit caught mid-change only costs one sample
  always_ff @(posedge test_port_clock_i or negedge test_port_reset_n_i)
  begin
    if (!test_port_reset_n_i)
    begin
      core_s1 <= '0;
      core_s2 <= '0;
      pin_s1  <= '0;
      pin_s2  <= '0;
    end
    else
    begin
      core_s1 <= core_out_i;
      core_s2 <= core_s1;
      pin_s1  <= pin_in_i;
      pin_s2  <= pin_s1;
    end
  end

  // controller next-state from sampled state select
  // five clocks with select high reach reset from any state
  always_comb
  begin
    next_state = state;
    unique case (state)
      bstap_pkg::ST_RESET:    next_state = test_state_select_i ? bstap_pkg::ST_RESET   : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_IDLE:     next_state = test_state_select_i ? bstap_pkg::ST_SEL_DR  : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_DR:   next_state = test_state_select_i ? bstap_pkg::ST_SEL_IR  : bstap_pkg::ST_CAP_DR;
      bstap_pkg::ST_CAP_DR:   next_state = test_state_select_i ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_SHIFT_DR: next_state = test_state_select_i ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_EXIT1_DR: next_state = test_state_select_i ? bstap_pkg::ST_UPD_DR  : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_PAUSE_DR: next_state = test_state_select_i ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_EXIT2_DR: next_state = test_state_select_i ? bstap_pkg::ST_UPD_DR  : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_UPD_DR:   next_state = test_state_select_i ? bstap_pkg::ST_SEL_DR  : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_IR:   next_state = test_state_select_i ? bstap_pkg::ST_RESET   : bstap_pkg::ST_CAP_IR;
      bstap_pkg::ST_CAP_IR:   next_state = test_state_select_i ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_SHIFT_IR: next_state = test_state_select_i ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_EXIT1_IR: next_state = test_state_select_i ? bstap_pkg::ST_UPD_IR  : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_PAUSE_IR: next_state = test_state_select_i ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_EXIT2_IR: next_state = test_state_select_i ? bstap_pkg::ST_UPD_IR  : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_UPD_IR:   next_state = test_state_select_i ? bstap_pkg::ST_SEL_DR  : bstap_pkg::ST_IDLE;
      default:                next_state = bstap_pkg::ST_RESET;  // illegal code recovers
    endcase
  end

  // data and instruction paths, all captured on the rising edge
  // capture puts core values in the low half, pin levels in the high half
  always_comb
  begin
    next_ir_shift   = ir_shift;
    next_ir         = ir;
    next_bypass_bit = bypass_bit;
    next_bsr_shift  = bsr_shift;
    next_bsr_upd    = bsr_upd;
    unique case (state)
      bstap_pkg::ST_RESET:    next_ir = bstap_pkg::IR_RESET;
      bstap_pkg::ST_CAP_IR:   next_ir_shift = bstap_pkg::IR_CAPTURE;
      bstap_pkg::ST_SHIFT_IR: next_ir_shift = {test_serial_in_i, ir_shift[bstap_pkg::IR_W-1:1]};
      bstap_pkg::ST_UPD_IR:   next_ir = ir_shift;
      bstap_pkg::ST_CAP_DR:
      begin
        next_bypass_bit = 1'b0;
        next_bsr_shift  = {pin_s2, core_s2};
      end
      bstap_pkg::ST_SHIFT_DR:
      begin
        if (is_bsr_instr(ir))
          next_bsr_shift = {test_serial_in_i, bsr_shift[2*NPINS-1:1]};
        else
          next_bypass_bit = test_serial_in_i;
      end
      bstap_pkg::ST_UPD_DR:
      begin
        if (is_bsr_instr(ir))
          next_bsr_upd = bsr_shift[NPINS-1:0];
      end
      default: ;
    endcase
    next_ext_q      = (next_ir == bstap_pkg::IR_EXTEST);  // a flop, not a decode, feeds the sync
  end

  // rising-edge registers; low test reset acts without a clock edge
  // ext_q follows next_ir so it moves on the same edge as ir
  always_ff @(posedge test_port_clock_i or negedge test_port_reset_n_i)
  begin
    if (!test_port_reset_n_i)
    begin
      state      <= bstap_pkg::ST_RESET;
      ir_shift   <= '0;
      ir         <= bstap_pkg::IR_RESET;
      bypass_bit <= 1'b0;
      bsr_shift  <= '0;
      bsr_upd    <= '0;
      ext_q      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      ir_shift   <= next_ir_shift;
      ir         <= next_ir;
      bypass_bit <= next_bypass_bit;
      bsr_shift  <= next_bsr_shift;
      bsr_upd    <= next_bsr_upd;
      ext_q      <= next_ext_q;
    end
  end

  // serial output selection for the falling edge
  // enable drops outside the shift states so the pin floats
  always_comb
  begin
    next_tdo_q = tdo_q;
    next_oe_q  = 1'b0;
    if (state == bstap_pkg::ST_SHIFT_IR)
    begin
      next_tdo_q = ir_shift[0];
      next_oe_q  = 1'b1;
    end
    else if (state == bstap_pkg::ST_SHIFT_DR)
    begin
      next_oe_q  = 1'b1;
      if (is_bsr_instr(ir))
        next_tdo_q = bsr_shift[0];
      else
        next_tdo_q = bypass_bit;
    end
  end

  // output updates half a cycle later so the tester samples a settled bit
  // test reset clears both at once, so the pin is released in reset
  always_ff @(negedge test_port_clock_i or negedge test_port_reset_n_i)
  begin
    if (!test_port_reset_n_i)
    begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      tdo_q <= next_tdo_q;
      oe_q  <= next_oe_q;
    end
  end

  // pin and enable straight from the falling-edge flops
  assign test_serial_out_o    = tdo_q;
  assign test_serial_out_oe_o = oe_q;  // released when not shifting

  // extest level crosses into mclk domain through two flops
  // the source is a single flop, never a decode, so no glitch is caught
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_q;
      ext_s2 <= ext_s1;
    end
  end

  // pins follow the core unless extest drives them; output clocks never pass here
  // limitation: update flops drive pins from the test domain; levels hold between updates
  assign scan_mode_o = ext_s2;
  assign pin_out_o   = ext_s2 ? bsr_upd : core_out_i;

endmodule : bstap_port

//--- bstap_port_props.sv
// checker: timing relations at the test link of the scan port
// assumes it is bound to bstap_port and the test clock idles low
module bstap_port_props (
  // functional side
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic scan_mode_o,
  // test link
  input wire logic test_port_clock_i,
  input wire logic test_port_reset_n_i,
  input wire logic test_state_select_i,
  input wire logic test_serial_in_i,
  input wire logic test_serial_out_o,
  input wire logic test_serial_out_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // short views of the link
  wire tck    = test_port_clock_i;
  wire trst_n = test_port_reset_n_i;
  wire tms    = test_state_select_i;
  wire tdo    = test_serial_out_o;
  wire oe     = test_serial_out_oe_o;
  logic [1:0] hi_val;
  // output level held over the high phase
  always_ff @(posedge tck)
  begin
    hi_val <= {oe, tdo};
  end
  a_reset_quiet: assert property (@(posedge mclk_i) !trst_n |-> !oe && !tdo)
    else $error("output active in test reset");
  a_out_on_fall: assert property (@(negedge tck) disable iff (!trst_n) {oe, tdo} == hi_val)
    else $error("output moved on rising edge");
  a_ir_capture: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] ##1 !tms ##1 tms [*2] ##1 !tms [*2] |=> oe && tdo)
    else $error("instruction capture bit wrong");
  a_bypass_one: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] ##1 !tms ##1 tms ##1 !tms [*3] |=> oe && tdo == $past(test_serial_in_i))
    else $error("bypass bit wrong");
  a_oe_release: assert property (@(posedge tck) disable iff (!trst_n) oe && tms |=> !oe)
    else $error("output still driven after shift");
  a_mode_clear: assert property (@(posedge mclk_i) disable iff (reset_i) !trst_n [*6] |-> !scan_mode_o)
    else $error("scan mode kept in test reset");
endmodule : bstap_port_props

//--- bstap_ctl.sv
// partner: outside tester driving the test link
// assumes the bench releases the test reset before the first frame
module bstap_ctl (
  // link to the port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  // clock stands low between frames
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 6 ns test clock; a released output reads as no stale level
  task step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #3;
    q = tdo_oe_i ? tdo_i : ~last;
    last = q;
    tck_o = 1'b1;
    #3;
    tck_o = 1'b0;
  endtask : step
  task walk(input int n, input logic [15:0] pat);
    logic q;
    for (int i = 0; i < n; i++)
      step(pat[i], 1'b0, q);
  endtask : walk
  // lsb first, select raised on the last bit
  task shift(input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = 16'h0000;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
  endtask : shift
endmodule : bstap_ctl

//--- bstap_port_tb.sv
// testbench: scan port driven by the tester model on its own clock
// assumes the default of eight scan pins
module bstap_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i, reset_i, trst_n, tck, tms, tdi, tdo, oe, mode;
  logic [7:0]  core, pins, pout;
  logic [15:0] got;
  int          n_errors, samples_checked, cycles;
  bstap_port dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .test_port_clock_i(tck), .test_port_reset_n_i(trst_n),
    .test_state_select_i(tms), .test_serial_in_i(tdi), .test_serial_out_o(tdo), .test_serial_out_oe_o(oe),
    .core_out_i(core), .pin_in_i(pins), .pin_out_o(pout), .scan_mode_o(mode));
  bstap_ctl tester_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(oe));
  // functional clock and hang guard
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // every path starts and ends in idle
  task load_ir(input logic [3:0] code);
    tester_u.walk(10, 16'h00DF);
    tester_u.shift(4, {12'h000, code}, got);
    chk(got, {12'h000, bstap_pkg::IR_CAPTURE});
    tester_u.walk(2, 16'h0001);
  endtask : load_ir
  task dr(input int n, input logic [15:0] din);
    tester_u.walk(3, 16'h0001);
    tester_u.shift(n, din, got);
    tester_u.walk(2, 16'h0001);
  endtask : dr
  task t_bypass;
    load_ir(4'h7);
    dr(4, 16'h000B);
    chk(got, 16'h0006);
    tester_u.walk(6, 16'h001F);
    dr(4, 16'h000B);
    chk(got, 16'h0006);
  endtask : t_bypass
  task t_extest;
    @(posedge mclk_i);
    #1;
    core = 8'hA5;
    pins = 8'h3C;
    load_ir(bstap_pkg::IR_EXTEST);
    dr(16, 16'h5A96);
    chk(got, 16'h3CA5);
    repeat (8) @(posedge mclk_i);
    #1;
    chk({8'h00, pout}, 16'h0096);
    chk({15'h0000, mode}, 16'h0001);
    load_ir(bstap_pkg::IR_SAMPLE);
    repeat (3) @(posedge mclk_i);
    #1;
    chk({8'h00, pout}, 16'h00A5);
    chk({15'h0000, mode}, 16'h0000);
  endtask : t_extest
  // reset arrives mid-shift with the test clock stopped
  task t_reset;
    load_ir(bstap_pkg::IR_EXTEST);
    tester_u.walk(4, 16'h0001);
    chk({15'h0000, oe}, 16'h0001);
    @(posedge mclk_i);
    #1;
    trst_n = 1'b0;
    #1;
    chk({15'h0000, oe}, 16'h0000);
    repeat (10) @(posedge mclk_i);
    #1;
    chk({7'h00, mode, pout}, 16'h00A5);
    trst_n = 1'b1;
    tester_u.walk(1, 16'h0000);
    dr(4, 16'h000B);
    chk(got, 16'h0006);
  endtask : t_reset
  task print_verdict;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    reset_i = 1'b1;
    trst_n = 1'b0;
    core = 8'h00;
    pins = 8'h00;
    repeat (6) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    trst_n = 1'b1;
    tester_u.walk(1, 16'h0000);
    t_bypass();
    t_extest();
    t_reset();
    print_verdict();
  end
endmodule : bstap_port_tb
bind bstap_port bstap_port_props props_u (.mclk_i(mclk_i), .reset_i(reset_i), .scan_mode_o(scan_mode_o),
  .test_port_clock_i(test_port_clock_i), .test_port_reset_n_i(test_port_reset_n_i),
  .test_state_select_i(test_state_select_i), .test_serial_in_i(test_serial_in_i),
  .test_serial_out_o(test_serial_out_o), .test_serial_out_oe_o(test_serial_out_oe_o));
